// ==== hdl/rfl_pkg.sv ====
// What this block does
// - each fan channel has its own loop, drive output and tach input.
// - drive update uses P, I and D terms of tach count error.
// - target is reference clocks per revolution, rewritable any time.
// - all-ones target switches the fan drive off in loop mode.
// - stalled fan is flagged, alert pulled low; in loop mode restarted at full drive.
// - tach reference selectable: external 32.768 kHz or internal 32 kHz.
// - 3-bit update time 100..1600 ms, reset code 011 (400 ms).
// - 2-bit error window 0/50/100/200 RPM stops adjustment, default 0.
// - loop disabled after reset until software sets loop enable.
// - derivative option none, basic, step-bypass, or both (gain 2).
// - gain codes 00=1x, 10=2x, 01=4x default, 11=8x.
// - where the ramp limit applies, drive changes by at most the step value per update interval.
// - ramp limit in loop mode unless a step-bypass option is set; in direct mode when ramp enabled.
// - default loop settings ignore the maximum step limit.
// - loop never drives below minimum drive unless target is all ones.
// - tach measured continuously over programmed edges in both modes.
// - edge select 00..11 gives 3, 5, 7, 9 edges, default 01.
// - tach works regardless of drive; low direct drive may flag stall.
// - tach reading holds reference clocks per fan revolution.
// - measurement range covers fans up to 16000 RPM.
// - target above valid count is ignored, drive held.
// - loop checks stall only at each update interval.
package rfl_pkg;

    // timing
    localparam int PCLK_PERIOD_NS = 10;
    localparam int PCLK_HZ        = 100_000_000;
    localparam int INT_REF_HZ     = 32_000;
    localparam int REF_DIV        = PCLK_HZ / INT_REF_HZ;
    localparam int MS_PERIOD_NS   = 1_000_000;
    localparam int MS_CYCLES      = MS_PERIOD_NS / PCLK_PERIOD_NS;

    // rpm per count factor for two-pole fan, five edges
    localparam logic [21:0] RPM_K = 22'h3c_0000;
    localparam int          PID_SHIFT = 4;
    localparam logic [7:0]  FULL_DRIVE = 8'hff;

    // register map
    localparam logic [6:0] GLB_BLK   = 7'h00;
    localparam logic [2:0] GLB_CFG   = 3'h0;
    localparam logic [2:0] GLB_STAT  = 3'h1;
    localparam logic [2:0] CH_CFG    = 3'h0;
    localparam logic [2:0] CH_GAIN   = 3'h1;
    localparam logic [2:0] CH_DRIVE  = 3'h2;
    localparam logic [2:0] CH_STEP   = 3'h3;
    localparam logic [2:0] CH_MIN    = 3'h4;
    localparam logic [2:0] CH_VALID  = 3'h5;
    localparam logic [2:0] CH_TARGET = 3'h6;
    localparam logic [2:0] CH_READ   = 3'h7;

    // field positions
    localparam int EXT_SEL_BIT = 0;
    localparam int LOOP_EN_BIT = 0;
    localparam int EDGES_LSB   = 1;
    localparam int UPD_LSB     = 3;
    localparam int RAMP_BIT    = 6;
    localparam int WIN_LSB     = 7;
    localparam int DOPT_LSB    = 9;
    localparam int KP_LSB      = 0;
    localparam int KI_LSB      = 2;
    localparam int KD_LSB      = 4;

    // reset values
    localparam logic [1:0]  EDGES_RST  = 2'h1;
    localparam logic [2:0]  UPD_RST    = 3'h3;
    localparam logic [1:0]  WIN_RST    = 2'h0;
    localparam logic [1:0]  DOPT_RST   = 2'h3;
    localparam logic [1:0]  GAIN_RST   = 2'h1;
    localparam logic [7:0]  STEP_RST   = 8'h10;
    localparam logic [7:0]  MIN_RST    = 8'h33;
    localparam logic [15:0] VALID_RST  = 16'hf000;
    localparam logic [15:0] TARGET_RST = 16'hffff;

    typedef struct packed {
        logic        en;
        logic [2:0]  idx;
        logic [31:0] data;
    } rfl_wr_t;

    typedef struct packed {
        logic               loop_en;
        logic [1:0]         edges;
        logic [2:0]         upd;
        logic               ramp_en;
        logic [1:0]         win;
        logic [1:0]         dopt;
        logic [1:0]         kp;
        logic [1:0]         ki;
        logic [1:0]         kd;
        logic [7:0]         dset;
        logic [7:0]         step;
        logic [7:0]         min_drv;
        logic [7:0]         drive;
        logic [15:0]        valid;
        logic [15:0]        target;
        logic [15:0]        reading;
        logic [15:0]        tick_cnt;
        logic [3:0]         edge_cnt;
        logic [2:0]         tsync;
        logic [10:0]        ms_cnt;
        logic signed [17:0] e1;
        logic signed [17:0] e2;
        logic               stall;
    } rfl_chan_t;

    localparam rfl_chan_t CHAN_RST = '{
        edges: EDGES_RST, upd: UPD_RST, win: WIN_RST, dopt: DOPT_RST,
        kp: GAIN_RST, ki: GAIN_RST, kd: GAIN_RST, step: STEP_RST,
        min_drv: MIN_RST, valid: VALID_RST, target: TARGET_RST, tsync: 3'h7,
        default: '0};

    // 00=1x 10=2x 01=4x 11=8x as a shift
    function automatic logic [1:0] rfl_gain_shift(input logic [1:0] code);
        return {code[0], code[1]};
    endfunction : rfl_gain_shift

    function automatic logic [10:0] rfl_upd_ms(input logic [2:0] code);
        unique case (code)
            3'h0: return 11'd100;
            3'h1: return 11'd200;
            3'h2: return 11'd300;
            3'h3: return 11'd400;
            3'h4: return 11'd500;
            3'h5: return 11'd800;
            3'h6: return 11'd1200;
            3'h7: return 11'd1600;
        endcase
    endfunction : rfl_upd_ms

    function automatic logic [7:0] rfl_win_rpm(input logic [1:0] code);
        unique case (code)
            2'h0: return 8'd0;
            2'h1: return 8'd50;
            2'h2: return 8'd100;
            2'h3: return 8'd200;
        endcase
    endfunction : rfl_win_rpm

endpackage : rfl_pkg

// ==== hdl/rfl_fan_loop.sv ====
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps

module rfl_channel (
    // clock and reset
    input  wire logic           pclk,
    input  wire logic           presetn,
    // timebase
    input  wire logic           ref_tick,
    input  wire logic           ms_tick,
    // fan side
    input  wire logic           tach_input,
    output logic [7:0]          drive,
    // register access
    input  wire rfl_pkg::rfl_wr_t wr,
    input  wire logic [2:0]     ridx,
    input  wire logic           stall_clr,
    output logic [31:0]         rdata,
    output logic                stall
);

    rfl_pkg::rfl_chan_t st;
    rfl_pkg::rfl_chan_t next_st;

    logic [3:0]         n_edges;
    logic               tach_edge;
    logic               upd_tick;
    logic [10:0]        upd_ms;
    logic signed [17:0] e;
    logic signed [17:0] de;
    logic signed [17:0] dd;
    logic signed [23:0] dp;
    logic signed [23:0] di;
    logic signed [23:0] dterm;
    logic signed [23:0] delta;
    logic signed [23:0] step_s;
    logic signed [24:0] cand;
    logic [7:0]         sat;
    logic [7:0]         new_drv;
    logic [16:0]        abs_e;
    logic [47:0]        win_lhs;
    logic [47:0]        win_rhs;
    logic               in_win;
    logic [7:0]         gap;

    always_comb begin
        next_st = st;
        tach_edge = st.tsync[2] ^ st.tsync[1];
        n_edges = 4'(3 + 2 * int'(st.edges));
        upd_ms = rfl_pkg::rfl_upd_ms(st.upd);
        upd_tick = 1'b0;

        // pid terms on count error, positive when too slow
        e = $signed({2'b00, st.reading}) - $signed({2'b00, st.target});
        de = e - st.e1;
        dd = e - (st.e1 <<< 1) + st.e2;
        dp = 24'(de) <<< rfl_pkg::rfl_gain_shift(st.kp);
        di = 24'(e) <<< rfl_pkg::rfl_gain_shift(st.ki);
        unique case (st.dopt)
            2'h0: dterm = '0;
            2'h1: dterm = 24'(dd) <<< rfl_pkg::rfl_gain_shift(st.kd);
            2'h2: dterm = 24'(dd) <<< rfl_pkg::rfl_gain_shift(st.kd);
            2'h3: dterm = (24'(dd) <<< rfl_pkg::rfl_gain_shift(st.kd)) <<< 1;
        endcase
        delta = (dp + di + dterm) >>> rfl_pkg::PID_SHIFT;
        step_s = $signed({16'h0000, st.step});
        // step options bypass the max step limit
        if (!st.dopt[1]) begin
            if (delta > step_s) begin
                delta = step_s;
            end else if (delta < -step_s) begin
                delta = -step_s;
            end
        end
        cand = $signed({17'h0_0000, st.drive}) + 25'(delta);
        if (cand < 0) begin
            sat = 8'h00;
        end else if (cand > 25'sd255) begin
            sat = 8'hff;
        end else begin
            sat = cand[7:0];
        end
        new_drv = (sat < st.min_drv) ? st.min_drv : sat;

        // window compare |1/r - 1/t| * K <= win, cross multiplied
        abs_e = e[17] ? 17'(-e) : 17'(e);
        win_lhs = 48'(abs_e) * 48'(rfl_pkg::RPM_K);
        win_rhs = 48'(rfl_pkg::rfl_win_rpm(st.win)) * 48'(st.target)
                  * 48'(st.reading);
        in_win = win_lhs <= win_rhs;

        gap = (st.dset > st.drive) ? st.dset - st.drive : st.drive - st.dset;

        // tach period measurement, free running in every mode
        next_st.tsync = {st.tsync[1:0], tach_input};
        if (tach_edge) begin
            if (st.edge_cnt == 4'h0) begin
                next_st.tick_cnt = '0;
                next_st.edge_cnt = 4'h1;
            end else if (st.edge_cnt + 4'h1 >= n_edges) begin
                next_st.reading = st.tick_cnt;
                next_st.tick_cnt = '0;
                next_st.edge_cnt = 4'h1;
            end else begin
                next_st.edge_cnt = st.edge_cnt + 4'h1;
            end
        end else if (ref_tick && st.edge_cnt != 4'h0) begin
            if (st.tick_cnt == 16'hffff) begin
                next_st.reading = 16'hffff;
                next_st.edge_cnt = 4'h0;
            end else begin
                next_st.tick_cnt = st.tick_cnt + 16'h0001;
            end
        end

        // update interval timer
        if (ms_tick) begin
            if (st.ms_cnt + 11'h001 >= upd_ms) begin
                next_st.ms_cnt = '0;
                upd_tick = 1'b1;
            end else begin
                next_st.ms_cnt = st.ms_cnt + 11'h001;
            end
        end

        // register writes
        if (wr.en) begin
            unique case (wr.idx)
                rfl_pkg::CH_CFG: begin
                    next_st.loop_en = wr.data[rfl_pkg::LOOP_EN_BIT];
                    next_st.edges = wr.data[rfl_pkg::EDGES_LSB +: 2];
                    next_st.upd = wr.data[rfl_pkg::UPD_LSB +: 3];
                    next_st.ramp_en = wr.data[rfl_pkg::RAMP_BIT];
                    next_st.win = wr.data[rfl_pkg::WIN_LSB +: 2];
                    next_st.dopt = wr.data[rfl_pkg::DOPT_LSB +: 2];
                end
                rfl_pkg::CH_GAIN: begin
                    next_st.kp = wr.data[rfl_pkg::KP_LSB +: 2];
                    next_st.ki = wr.data[rfl_pkg::KI_LSB +: 2];
                    next_st.kd = wr.data[rfl_pkg::KD_LSB +: 2];
                end
                rfl_pkg::CH_DRIVE:  next_st.dset = wr.data[7:0];
                rfl_pkg::CH_STEP:   next_st.step = wr.data[7:0];
                rfl_pkg::CH_MIN:    next_st.min_drv = wr.data[7:0];
                rfl_pkg::CH_VALID:  next_st.valid = wr.data[15:0];
                rfl_pkg::CH_TARGET: next_st.target = wr.data[15:0];
                rfl_pkg::CH_READ: ;
            endcase
        end

        // clear first so a same-cycle stall still sets
        if (stall_clr) begin
            next_st.stall = 1'b0;
        end

        if (!st.loop_en) begin
            if (st.reading > st.valid) begin
                next_st.stall = 1'b1;
            end
            next_st.e1 = '0;
            next_st.e2 = '0;
            if (!st.ramp_en) begin
                next_st.drive = st.dset;
            end else if (upd_tick) begin
                if (gap <= st.step) begin
                    next_st.drive = st.dset;
                end else if (st.dset > st.drive) begin
                    next_st.drive = st.drive + st.step;
                end else begin
                    next_st.drive = st.drive - st.step;
                end
            end
        end else if (upd_tick) begin
            if (st.target == 16'hffff) begin
                next_st.drive = 8'h00;
                next_st.e1 = '0;
                next_st.e2 = '0;
            end else if (st.target > st.valid) begin
                next_st.drive = st.drive;
            end else if (st.reading > st.valid) begin
                next_st.stall = 1'b1;
                next_st.drive = rfl_pkg::FULL_DRIVE;
                next_st.e1 = '0;
                next_st.e2 = '0;
            end else if (!in_win) begin
                next_st.drive = new_drv;
                next_st.e2 = st.e1;
                next_st.e1 = e;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= rfl_pkg::CHAN_RST;
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        rdata = 32'h0000_0000;
        unique case (ridx)
            rfl_pkg::CH_CFG: begin
                rdata[rfl_pkg::LOOP_EN_BIT] = st.loop_en;
                rdata[rfl_pkg::EDGES_LSB +: 2] = st.edges;
                rdata[rfl_pkg::UPD_LSB +: 3] = st.upd;
                rdata[rfl_pkg::RAMP_BIT] = st.ramp_en;
                rdata[rfl_pkg::WIN_LSB +: 2] = st.win;
                rdata[rfl_pkg::DOPT_LSB +: 2] = st.dopt;
            end
            rfl_pkg::CH_GAIN: begin
                rdata[rfl_pkg::KP_LSB +: 2] = st.kp;
                rdata[rfl_pkg::KI_LSB +: 2] = st.ki;
                rdata[rfl_pkg::KD_LSB +: 2] = st.kd;
            end
            rfl_pkg::CH_DRIVE:  rdata[7:0] = st.drive;
            rfl_pkg::CH_STEP:   rdata[7:0] = st.step;
            rfl_pkg::CH_MIN:    rdata[7:0] = st.min_drv;
            rfl_pkg::CH_VALID:  rdata[15:0] = st.valid;
            rfl_pkg::CH_TARGET: rdata[15:0] = st.target;
            rfl_pkg::CH_READ:   rdata[15:0] = st.reading;
        endcase
    end

    assign drive = st.drive;
    assign stall = st.stall;

endmodule : rfl_channel

module rfl_fan_loop #(
    parameter int NUM_CH    = 5,
    parameter int MS_CYCLES = rfl_pkg::MS_CYCLES
) (
    // clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    // reference clock pin
    input  wire logic                   ext_ref_clk,
    // fans
    input  wire logic [NUM_CH-1:0]      tach_input,
    output logic [NUM_CH-1:0][7:0]      fan_drive,
    output logic                        alert_n
);

    typedef struct packed {
        logic [31:0] prdata;
        logic        pslverr;
        logic        ext_sel;
        logic [2:0]  csync;
        logic [11:0] ref_div;
        logic [19:0] ms_div;
        logic        alert_n;
    } rfl_top_t;

    rfl_top_t st;
    rfl_top_t next_st;

    logic [6:0]              blk;
    logic [2:0]              idx;
    logic                    glb_hit;
    logic                    ch_hit;
    logic                    acc_wr;
    logic                    ref_tick;
    logic                    ms_tick;
    logic [NUM_CH-1:0]       stall;
    logic [NUM_CH-1:0]       stall_clr;
    logic [NUM_CH-1:0][31:0] ch_rdata;
    logic [31:0]             sel_rdata;

    assign blk = paddr[11:5];
    assign idx = paddr[4:2];
    assign glb_hit = blk == rfl_pkg::GLB_BLK && idx <= rfl_pkg::GLB_STAT;
    assign ch_hit = blk != rfl_pkg::GLB_BLK && blk <= 7'(NUM_CH);
    assign acc_wr = psel && penable && pwrite;
    // external clock edge or internal 32 kHz divider
    assign ref_tick = st.ext_sel ? (st.csync[1] && !st.csync[2])
                                 : st.ref_div == 12'(rfl_pkg::REF_DIV - 1);
    assign ms_tick = st.ms_div == 20'(MS_CYCLES - 1);

    // one independent loop per channel
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        rfl_pkg::rfl_wr_t ch_wr;
        assign ch_wr.en = acc_wr && blk == 7'(g + 1);
        assign ch_wr.idx = idx;
        assign ch_wr.data = pwdata;
        assign stall_clr[g] = acc_wr && glb_hit && idx == rfl_pkg::GLB_STAT
                              && pwdata[g];
        rfl_channel u_ch (
            .pclk       (pclk),
            .presetn    (presetn),
            .ref_tick   (ref_tick),
            .ms_tick    (ms_tick),
            .tach_input (tach_input[g]),
            .drive      (fan_drive[g]),
            .wr         (ch_wr),
            .ridx       (idx),
            .stall_clr  (stall_clr[g]),
            .rdata      (ch_rdata[g]),
            .stall      (stall[g])
        );
    end

    always_comb begin
        sel_rdata = 32'h0000_0000;
        if (glb_hit) begin
            if (idx == rfl_pkg::GLB_CFG) begin
                sel_rdata[rfl_pkg::EXT_SEL_BIT] = st.ext_sel;
            end else begin
                sel_rdata[NUM_CH-1:0] = stall;
            end
        end else if (ch_hit) begin
            sel_rdata = ch_rdata[3'(blk - 7'h01)];
        end
    end

    always_comb begin
        next_st = st;
        next_st.csync = {st.csync[1:0], ext_ref_clk};
        next_st.ref_div = (st.ref_div == 12'(rfl_pkg::REF_DIV - 1))
                          ? 12'h000 : st.ref_div + 12'h001;
        next_st.ms_div = ms_tick ? 20'h0_0000 : st.ms_div + 20'h0_0001;
        next_st.alert_n = ~|stall;
        // read data and error captured in setup phase
        if (psel && !penable) begin
            next_st.prdata = pwrite ? 32'h0000_0000 : sel_rdata;
            next_st.pslverr = !(glb_hit || ch_hit);
        end
        if (acc_wr && glb_hit && idx == rfl_pkg::GLB_CFG) begin
            next_st.ext_sel = pwdata[rfl_pkg::EXT_SEL_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{alert_n: 1'b1, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pslverr = st.pslverr;
    assign pready = 1'b1;
    assign alert_n = st.alert_n;

endmodule : rfl_fan_loop

// ==== sim/rfl_fan_model.sv ====
`timescale 1ns/1ps
module rfl_fan_model #(
    parameter int HALF = 10
) (
    // reference and drive
    input  wire logic       ref_clk,
    input  wire logic [7:0] drive,
    // tach line
    output logic            tach
);
    int cnt = 0;

    initial tach = 1'b1;

    // stopped fan releases the line, pull-up reads high
    always @(negedge ref_clk) begin
        if (drive == 8'h00) begin
            tach <= 1'b1;
            cnt  <= 0;
        end else if (cnt == HALF - 1) begin
            tach <= ~tach;
            cnt  <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : rfl_fan_model

// ==== sim/rfl_fan_loop_sva.sv ====
`timescale 1ns/1ps
module rfl_fan_loop_sva #(
    parameter int NUM_CH    = 5,
    parameter int MS_CYCLES = 100000
) (
    // clock and reset
    input wire logic                   pclk,
    input wire logic                   presetn,
    // apb
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [11:0]            paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    // pins
    input wire logic                   ext_ref_clk,
    input wire logic [NUM_CH-1:0]      tach_input,
    input wire logic [NUM_CH-1:0][7:0] fan_drive,
    input wire logic                   alert_n
);
    localparam int MIN_GAP = 100 * MS_CYCLES - 1;
    logic        wr;
    logic [7:0]  d0;
    logic        loop_en;
    logic        ramp_en;
    logic        lp_prev;
    logic [7:0]  step_v;
    logic [7:0]  min_v;
    logic [15:0] tgt;
    logic [31:0] gap;

    assign wr = psel && penable && pwrite && pready;
    assign d0 = fan_drive[0];

    // shadow of channel one settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_en <= 1'b0;
            ramp_en <= 1'b0;
            step_v  <= 8'h10;
            min_v   <= 8'h33;
            tgt     <= 16'hffff;
        end else if (wr) begin
            case (paddr)
                12'h020: begin
                    loop_en <= pwdata[0];
                    ramp_en <= pwdata[6];
                end
                12'h02c: step_v <= pwdata[7:0];
                12'h030: min_v <= pwdata[7:0];
                12'h038: tgt <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // cycles since the last drive change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap     <= '0;
            lp_prev <= 1'b0;
        end else if ($changed(d0)) begin
            gap     <= '0;
            lp_prev <= loop_en;
        end else begin
            gap     <= gap + 32'h1;
            lp_prev <= lp_prev && loop_en;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_drive_wr;
        wr && paddr == 12'h028 && !loop_en && !ramp_en;
    endsequence
    sequence s_ramp_move;
        !loop_en && ramp_en && $changed(d0);
    endsequence
    property p_direct;
        logic [7:0] v;
        (s_drive_wr, v = pwdata[7:0]) |=> ##1 d0 == v;
    endproperty

    a_no_wait_state: assert property (psel && penable |-> pready)
        else $error("access phase stretched");
    a_unmapped_error: assert property (psel && penable && paddr[11:5] > NUM_CH |-> pslverr && prdata == 32'h0)
        else $error("missing channel block not refused");
    a_mapped_okay: assert property (psel && penable && paddr[11:5] <= NUM_CH && (paddr[11:5] != 7'h00 || paddr[4:2] < 3'h2) |-> !pslverr)
        else $error("mapped access refused");
    a_reset_idle: assert property ($rose(presetn) |-> alert_n && fan_drive == '0)
        else $error("fans not idle after reset");
    a_direct_follow: assert property (p_direct)
        else $error("direct drive not applied next cycle");
    a_ramp_step: assert property (s_ramp_move |-> ((d0 >= $past(d0)) ? (d0 - $past(d0)) : ($past(d0) - d0)) <= step_v)
        else $error("ramped drive moved more than step");
    a_min_floor: assert property (loop_en && tgt != 16'hffff && $changed(d0) |-> d0 >= min_v)
        else $error("loop drive below minimum");
    a_update_spacing: assert property (loop_en && lp_prev && $changed(d0) |-> gap >= MIN_GAP)
        else $error("loop drive changed between updates");
endmodule : rfl_fan_loop_sva

bind rfl_fan_loop rfl_fan_loop_sva #(.NUM_CH(NUM_CH), .MS_CYCLES(MS_CYCLES)) u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_ref_clk(ext_ref_clk), .tach_input(tach_input), .fan_drive(fan_drive),
    .alert_n(alert_n));

// ==== sim/rfl_fan_loop_tb.sv ====
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin err_count++; $display("[FAIL] %0t %s", $time, m); end end
module rfl_fan_loop_tb;
    localparam int NCH = 2;
    localparam int MSC = 20;
    localparam int UPD = 100 * MSC;
    logic                pclk        = 1'b0;
    logic                presetn     = 1'b0;
    logic                psel        = 1'b0;
    logic                penable     = 1'b0;
    logic                pwrite      = 1'b0;
    logic                ext_ref_clk = 1'b0;
    logic [11:0]         paddr       = '0;
    logic [31:0]         pwdata      = '0;
    logic [31:0]         prdata;
    logic [31:0]         rd;
    logic                pready;
    logic                pslverr;
    logic                er;
    logic                alert_n;
    logic [7:0]          hold;
    wire  [NCH-1:0]      tach;
    logic [NCH-1:0][7:0] fan_drive;
    logic [31:0]         rst_v [7] = '{32'h0000_061a, 32'h0000_0015, 32'h0000_0000,
        32'h0000_0010, 32'h0000_0033, 32'h0000_f000, 32'h0000_ffff};
    int                  err_count = 0;
    int                  n_checks  = 0;

    always #5 pclk = ~pclk;
    always #500 ext_ref_clk = ~ext_ref_clk;

    rfl_fan_loop #(.NUM_CH(NCH), .MS_CYCLES(MSC)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_ref_clk(ext_ref_clk), .tach_input(tach), .fan_drive(fan_drive), .alert_n(alert_n));
    rfl_fan_model #(.HALF(10)) fan0 (.ref_clk(ext_ref_clk), .drive(fan_drive[0]), .tach(tach[0]));
    rfl_fan_model #(.HALF(10)) fan1 (.ref_clk(ext_ref_clk), .drive(fan_drive[1]), .tach(tach[1]));

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string m);
        apb(1'b0, a, 32'h0);
        `CHK(rd, exp, m)
    endtask : rchk

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        `CHK(fan_drive[0], 8'h00, "drive not off after reset")
        for (int i = 0; i < 7; i++) begin
            rchk(12'h020 + 12'(4 * i), rst_v[i], "reset value");
        end
        for (int i = 0; i < 2; i++) begin
            apb(1'b0, (i == 0) ? 12'h008 : 12'h060, 32'h0);
            `CHK(er, 1'b1, "unmapped access accepted")
        end
        $display("test reset and map done");
        apb(1'b1, 12'h000, 32'h0000_0001);
        apb(1'b1, 12'h028, 32'h0000_0080);
        @(posedge pclk);
        #1;
        `CHK(fan_drive[0], 8'h80, "direct drive not applied")
        for (int e = 0; e < 4; e++) begin
            apb(1'b1, 12'h020, 32'(e * 2));
            repeat ((2 * e + 2) * 2000 + 300) @(posedge pclk);
            rchk(12'h03c, 32'((2 * e + 2) * 10), "tach count");
        end
        rchk(12'h05c, 32'h0, "idle channel count");
        `CHK(fan_drive[1], 8'h00, "idle fan driven")
        apb(1'b1, 12'h020, 32'h0000_0002);
        $display("test tach done");
        apb(1'b1, 12'h034, 32'h0000_0020);
        repeat (10) @(posedge pclk);
        rchk(12'h004, 32'h0000_0001, "stall not flagged");
        `CHK(alert_n, 1'b0, "alert not raised")
        apb(1'b1, 12'h034, 32'h0000_0100);
        apb(1'b1, 12'h004, 32'h0000_0001);
        rchk(12'h004, 32'h0, "stall not cleared");
        `CHK(alert_n, 1'b1, "alert stuck")
        $display("test stall done");
        apb(1'b1, 12'h020, 32'h0000_0042);
        apb(1'b1, 12'h028, 32'h0000_00ff);
        for (int k = 0; k < UPD + 50 && fan_drive[0] == 8'h80; k++) @(posedge pclk);
        #1;
        `CHK(fan_drive[0], 8'h90, "ramp step wrong")
        repeat (100) @(posedge pclk);
        `CHK(fan_drive[0], 8'h90, "ramp moved between updates")
        $display("test ramp done");
        apb(1'b1, 12'h020, 32'h0000_0002);
        apb(1'b1, 12'h028, 32'h0000_0040);
        apb(1'b1, 12'h038, 32'h0000_0100);
        apb(1'b1, 12'h020, 32'h0000_0003);
        repeat (4 * UPD + 100) @(posedge pclk);
        `CHK(fan_drive[0], 8'h33, "loop drive not at floor")
        apb(1'b1, 12'h038, 32'h0000_0020);
        repeat (3 * UPD) @(posedge pclk);
        `CHK(fan_drive[0] > 8'h33, 1'b1, "loop did not speed up")
        apb(1'b1, 12'h038, 32'h0000_0200);
        @(posedge pclk);
        #1;
        hold = fan_drive[0];
        repeat (2 * UPD) @(posedge pclk);
        `CHK(fan_drive[0], hold, "drive moved on invalid target")
        apb(1'b1, 12'h038, 32'h0000_ffff);
        repeat (2 * UPD + 100) @(posedge pclk);
        `CHK(fan_drive[0], 8'h00, "fan not off on all ones target")
        $display("test loop done");
        print_verdict();
    end

    initial begin
        repeat (100000) @(posedge pclk);
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict();
    end
endmodule : rfl_fan_loop_tb
